// File: hdl/mis_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module mis_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 40
) (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  // control
  input  wire logic                         push,
  input  wire logic [W-1:0]                 push_data,
  input  wire logic                         pop,
  input  wire logic                         flush,
  // state
  output logic      [W-1:0]                 head,
  output logic                              empty,
  output logic                              full,
  output logic      [$clog2(DEPTH+1)-1:0]   count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  initial begin
    if (DEPTH < 2 || W < 1) $error("mis_fifo: bad parameters");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [CW-1:0] cnt_q;
  logic          do_push;
  logic          do_pop;

  assign empty   = (cnt_q == '0);
  assign full    = (cnt_q == FULL_CNT);
  assign count   = cnt_q;
  assign head    = mem[rd_q];
  assign do_push = push && !full && !flush;
  assign do_pop  = pop && !empty && !flush;

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_q] <= push_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : mis_fifo
`default_nettype wire

// File: hdl/mis_out_track.sv
`timescale 1ns/1ps
`default_nettype none
module mis_out_track #(
  parameter int AW = 16
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // buffer set-up by software
  input  wire logic          buf_load,
  input  wire logic [AW-1:0] output_byte_pointer,
  input  wire logic [AW-1:0] last_output_byte_addr,
  // transmitter side
  input  wire logic          fetch_req,
  input  wire logic          abort,
  output logic      [AW-1:0] fetch_addr,
  output logic               fetch_strobe,
  output logic               out_done,
  output logic               active
);
  initial begin
    if (AW < 2) $error("mis_out_track: bad width");
  end

  logic [AW-1:0] ptr_q;
  logic [AW-1:0] lob_q;
  logic          first_q;
  logic          act_q;
  logic [AW:0]   nxt;
  logic          last_byte;

  assign nxt       = {1'b0, ptr_q} + 1'b1;
  assign active    = act_q;
  assign last_byte = (nxt[AW-1:0] == lob_q) || (first_q && ({1'b0, lob_q} < nxt));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q        <= '0;
      lob_q        <= '0;
      first_q      <= 1'b0;
      act_q        <= 1'b0;
      fetch_addr   <= '0;
      fetch_strobe <= 1'b0;
      out_done     <= 1'b0;
    end else begin
      fetch_strobe <= 1'b0;
      out_done     <= 1'b0;
      if (abort) begin
        act_q <= 1'b0;
      end else if (buf_load) begin
        ptr_q   <= output_byte_pointer;
        lob_q   <= last_output_byte_addr;
        first_q <= 1'b1;
        act_q   <= 1'b1;
      end else if (fetch_req && act_q) begin
        ptr_q        <= nxt[AW-1:0];
        fetch_addr   <= nxt[AW-1:0];
        fetch_strobe <= 1'b1;
        first_q      <= 1'b0;
        if (last_byte) begin
          out_done <= 1'b1;
          act_q    <= 1'b0;
        end
      end
    end
  end
endmodule : mis_out_track
`default_nettype wire

// File: hdl/mis_pkg.sv
package mis_pkg;
  localparam int          STAT_W        = 16;
  localparam int          PORT_W        = 7;
  localparam int          ADDR_W        = 16;
  localparam int          STACK_DEPTH   = 40;
  // status word field positions
  localparam int          BIT_TICK      = 0;
  localparam int          BIT_OVF       = 1;
  localparam int          BIT_IN_DONE   = 2;
  localparam int          BIT_OUT_DONE  = 3;
  localparam int          PORT_LSB      = 4;
  localparam int          PORT_MSB      = 10;
  // control block size selects and id lsb in the control word address
  localparam logic [1:0]  BLK_40_OCT    = 2'h0;
  localparam logic [1:0]  BLK_20_OCT    = 2'h1;
  localparam logic [1:0]  BLK_10_OCT    = 2'h2;
  localparam int          ID_LSB_40     = 5;
  localparam int          ID_LSB_20     = 4;
  localparam int          ID_LSB_10     = 3;
  // real-time tick
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          TICK_MS       = 10;
  localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  // port zero defaults after bus reset
  localparam logic [2:0]  BAUD_9600     = 3'h7;
  localparam logic [1:0]  CHAR_LEN_8    = 2'h3;
  localparam logic        PARITY_NONE   = 1'h0;
  localparam logic        STOP_TWO      = 1'h1;
  localparam logic [7:0]  BASE_DEFAULT  = 8'h00;
  // queued entry: {out_done, in_done, port}
  localparam int          ENTRY_W       = PORT_W + 2;
endpackage : mis_pkg

// File: hdl/mis_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - fetching the byte at the last-output address raises output-done
// - one-byte buffers work when last address is pointer plus one
// - last address below pointer plus one sends one byte, then done
// - status-read instruction returns the interrupt status word
// - pending status words queue in a forty-entry fifo
// - start pulse pops the stack; read-and-pop reads then removes
// - pop leaving entries keeps done set and asks a new interrupt
// - empty-stack read with no tick or overflow gives bits 0-3 zero, port field undefined
// - enabled clock sets tick bit every 10 ms and interrupts
// - non-clock words keep bit 0 zero; status read clears tick
// - tick and a port event may share one status word
// - overflow at forty pending sets bit 1; host scans all ports
// - bits 2 and 3 flag input and output done for named port
// - port id from address bits per block size; bits 11-15 zero
// - reset or clear stops mux and clock, clears flags, idles outputs
// - bus reset also asserts controls and restores port zero defaults
// - clear pulse keeps port parameters as software left them
// - pulse starts the real-time clock, mux untouched
// - start on empty leaves done clear unless a tick is pending; after overflow it empties stack
// - output pointer increments before each fetch
// - pause halts channel transfers, characters in flight finish
// - run starts mux; its pulse variant also starts the clock
module mis_top
  import mis_pkg::*;
#(
  parameter int TICK_COUNT = mis_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // host i/o instructions, one-cycle strobes
  input  wire logic                        read_status_instr,
  input  wire logic                        start_pulse_instr,
  input  wire logic                        clear_pulse_instr,
  input  wire logic                        bus_reset_instr,
  input  wire logic                        pulse_instr,
  input  wire logic                        run_instr,
  input  wire logic                        run_with_clock_instr,
  input  wire logic                        pause_transfers_instr,
  input  wire logic [7:0]                  base_addr_wr_data,
  input  wire logic                        base_addr_wr,
  // host data-in bus and flags
  output logic      [mis_pkg::STAT_W-1:0]  status_data,
  output logic                             done_flag,
  output logic                             intr_req,
  // input-done events from the receive side
  input  wire logic                        in_done_evt,
  input  wire logic [mis_pkg::ADDR_W-1:0]  in_cw_addr,
  input  wire logic [1:0]                  blk_size_sel,
  // automatic output buffer
  input  wire logic                        ob_load,
  input  wire logic [mis_pkg::ADDR_W-1:0]  output_byte_pointer,
  input  wire logic [mis_pkg::ADDR_W-1:0]  last_output_byte_addr,
  input  wire logic [mis_pkg::ADDR_W-1:0]  out_cw_addr,
  input  wire logic                        ob_fetch_req,
  output logic      [mis_pkg::ADDR_W-1:0]  ob_fetch_addr,
  output logic                             ob_fetch_strobe,
  // mux state and port lines
  output logic                             mux_running,
  output logic                             dc_enable,
  output logic                             rtc_running,
  output logic                             data_out_idle,
  output logic                             dev_ctrl_assert,
  output logic      [2:0]                  port0_baud,
  output logic      [1:0]                  port0_char_len,
  output logic                             port0_parity,
  output logic                             port0_stop_two,
  output logic      [7:0]                  pcb_base
);
  import mis_pkg::*;

  localparam int TW = $clog2(TICK_COUNT + 1);
  localparam int CW = $clog2(STACK_DEPTH + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_COUNT - 1);

  initial begin
    if (TICK_COUNT < 2) $error("mis_top: TICK_COUNT too small");
  end

  logic                stop_all;
  logic                run_q;
  logic                pause_q;
  logic                rtc_q;
  logic [TW-1:0]       tick_cnt_q;
  logic                tick_q;
  logic                ovf_q;
  logic                busy_q;
  logic                out_pend_q;
  logic [PORT_W-1:0]   out_pend_port_q;
  logic                irq_q;
  logic                out_done;
  logic                tick_evt;
  logic                push;
  logic [ENTRY_W-1:0]  push_data;
  logic                fifo_pop;
  logic [ENTRY_W-1:0]  head;
  logic                empty;
  logic                full;
  logic [CW-1:0]       count;
  logic                event_now;
  logic [PORT_W-1:0]   in_port;
  logic [PORT_W-1:0]   out_port;

  function automatic logic [PORT_W-1:0] port_id(input logic [ADDR_W-1:0] a,
                                                input logic [1:0] sel);
    logic [PORT_W-1:0] r;
    r = a[ID_LSB_40 +: PORT_W];
    if (sel == BLK_20_OCT) begin
      r = a[ID_LSB_20 +: PORT_W];
    end else if (sel == BLK_10_OCT) begin
      r = a[ID_LSB_10 +: PORT_W];
    end
    return r;
  endfunction : port_id

  assign in_port  = port_id(in_cw_addr, blk_size_sel);
  assign out_port = port_id(out_cw_addr, blk_size_sel);
  // reset and clear share the stop
  assign stop_all = bus_reset_instr || clear_pulse_instr;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run_q   <= 1'b0;
      pause_q <= 1'b0;
    end else if (stop_all) begin
      run_q   <= 1'b0;
      pause_q <= 1'b0;
    end else if (run_instr || run_with_clock_instr) begin
      run_q   <= 1'b1;
      pause_q <= 1'b0;
    end else if (pause_transfers_instr) begin
      pause_q <= 1'b1;
    end
  end

  assign mux_running   = run_q;
  // pause only stops new fetches; the tracker finishes nothing early
  assign dc_enable     = run_q && !pause_q;
  assign data_out_idle = !run_q;
  assign rtc_running   = rtc_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rtc_q <= 1'b0;
    end else if (stop_all) begin
      rtc_q <= 1'b0;
    end else if (pulse_instr || run_with_clock_instr) begin
      rtc_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
    end else if (!rtc_q || tick_evt) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  assign tick_evt = rtc_q && (tick_cnt_q == TICK_LAST);

  // status read clears tick, a new tick wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 1'b0;
    end else if (stop_all) begin
      tick_q <= 1'b0;
    end else if (tick_evt) begin
      tick_q <= 1'b1;
    end else if (read_status_instr) begin
      tick_q <= 1'b0;
    end
  end

  // bus reset restores port zero, base and device controls; clear leaves them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dev_ctrl_assert <= 1'b1;
      port0_baud      <= BAUD_9600;
      port0_char_len  <= CHAR_LEN_8;
      port0_parity    <= PARITY_NONE;
      port0_stop_two  <= STOP_TWO;
      pcb_base        <= BASE_DEFAULT;
    end else if (bus_reset_instr) begin
      dev_ctrl_assert <= 1'b1;
      port0_baud      <= BAUD_9600;
      port0_char_len  <= CHAR_LEN_8;
      port0_parity    <= PARITY_NONE;
      port0_stop_two  <= STOP_TWO;
      pcb_base        <= BASE_DEFAULT;
    end else if (base_addr_wr && !run_q) begin
      // base is only taken while the mux is off
      pcb_base <= base_addr_wr_data;
    end
  end

  mis_out_track #(
    .AW(ADDR_W)
  ) u_out (
    .mclk                  (mclk),
    .rst_b                 (rst_b),
    .buf_load              (ob_load),
    .output_byte_pointer   (output_byte_pointer),
    .last_output_byte_addr (last_output_byte_addr),
    .fetch_req             (ob_fetch_req && dc_enable),
    .abort                 (stop_all),
    .fetch_addr            (ob_fetch_addr),
    .fetch_strobe          (ob_fetch_strobe),
    .out_done              (out_done),
    .active                ()
  );

  // output-done waits here when it meets an input-done
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_pend_q      <= 1'b0;
      out_pend_port_q <= '0;
    end else if (stop_all) begin
      out_pend_q <= 1'b0;
    end else if (out_done) begin
      out_pend_q      <= 1'b1;
      out_pend_port_q <= out_port;
    end else if (!in_done_evt) begin
      out_pend_q <= 1'b0;
    end
  end

  // one event per entry, input first
  always_comb begin
    push      = 1'b0;
    push_data = '0;
    if (in_done_evt) begin
      push      = 1'b1;
      push_data = {1'b0, 1'b1, in_port};
    end else if (out_pend_q) begin
      push      = 1'b1;
      push_data = {1'b1, 1'b0, out_pend_port_q};
    end
  end

  assign event_now = push && !stop_all;

  // overflow set wins over a clearing start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_q <= 1'b0;
    end else if (stop_all) begin
      ovf_q <= 1'b0;
    end else if (event_now && full) begin
      ovf_q <= 1'b1;
    end else if (start_pulse_instr && ovf_q) begin
      ovf_q <= 1'b0;
    end
  end

  assign fifo_pop = start_pulse_instr && !ovf_q;

  mis_fifo #(
    .W     (ENTRY_W),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .push      (event_now),
    .push_data (push_data),
    .pop       (fifo_pop),
    .flush     (stop_all || (start_pulse_instr && ovf_q)),
    .head      (head),
    .empty     (empty),
    .full      (full),
    .count     (count)
  );

  // busy marks a tracked output buffer in flight
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else if (stop_all || out_done) begin
      busy_q <= 1'b0;
    end else if (ob_load) begin
      busy_q <= 1'b1;
    end
  end

  // re-request after a pop that leaves entries
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= !stop_all && ((start_pulse_instr && !ovf_q && (count > CW'(1)))
               || event_now || tick_evt);
    end
  end

  // done follows whatever is still pending
  assign done_flag = !empty || ovf_q || tick_q;
  assign intr_req  = irq_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_data <= '0;
    end else if (read_status_instr) begin
      status_data <= {5'h00, head[PORT_W-1:0],
                      head[ENTRY_W-1] && !empty && !ovf_q,
                      head[ENTRY_W-2] && !empty && !ovf_q,
                      ovf_q, tick_q};
    end
  end

  // tick bit gone after a read
  property p_tick_clear;
    @(posedge mclk) disable iff (!rst_b)
      read_status_instr && !tick_evt |=> !tick_q;
  endproperty
  a_tick_clear: assert property (p_tick_clear) else $error("tick not cleared");

  property p_empty_read;
    @(posedge mclk) disable iff (!rst_b)
      read_status_instr && empty && !ovf_q && !tick_q |=> status_data[3:0] == 4'h0;
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read bits set");

  property p_high_zero;
    @(posedge mclk) disable iff (!rst_b)
      status_data[15:11] == 5'h00;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high bits nonzero");

  property p_ovf_set;
    @(posedge mclk) disable iff (!rst_b)
      event_now && full && !stop_all |=> ovf_q && done_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");

  property p_ovf_flush;
    @(posedge mclk) disable iff (!rst_b)
      start_pulse_instr && ovf_q && !event_now |=> empty && !ovf_q;
  endproperty
  a_ovf_flush: assert property (p_ovf_flush) else $error("overflow not flushed");

  property p_stop;
    @(posedge mclk) disable iff (!rst_b)
      stop_all |=> !run_q && !rtc_q && !done_flag && data_out_idle;
  endproperty
  a_stop: assert property (p_stop) else $error("stop incomplete");

  property p_pulse_rtc;
    @(posedge mclk) disable iff (!rst_b)
      pulse_instr && !stop_all |=> rtc_q && (run_q == $past(run_q));
  endproperty
  a_pulse_rtc: assert property (p_pulse_rtc) else $error("pulse misbehaved");

  property p_tick_period;
    @(posedge mclk) disable iff (!rst_b)
      tick_evt |=> !tick_evt [*2];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick too often");

  property p_repop_irq;
    @(posedge mclk) disable iff (!rst_b)
      start_pulse_instr && !ovf_q && !stop_all && count > CW'(1) |=> intr_req && done_flag;
  endproperty
  a_repop_irq: assert property (p_repop_irq) else $error("no re-interrupt");

  property p_clear_keeps;
    @(posedge mclk) disable iff (!rst_b)
      clear_pulse_instr && !bus_reset_instr |=> $stable(port0_baud) && $stable(pcb_base);
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) else $error("clear touched port0");

  property p_out_done_q;
    @(posedge mclk) disable iff (!rst_b)
      out_done && !in_done_evt && !stop_all |=> event_now ##1 !empty;
  endproperty
  a_out_done_q: assert property (p_out_done_q) else $error("output done lost");

  c_overflow: cover property (@(posedge mclk) disable iff (!rst_b) ovf_q && read_status_instr);
  c_tick_evt: cover property (@(posedge mclk) disable iff (!rst_b) tick_q && !empty && read_status_instr);
  c_out_done: cover property (@(posedge mclk) disable iff (!rst_b) out_done);
  c_repop:    cover property (@(posedge mclk) disable iff (!rst_b) start_pulse_instr && count > CW'(1));
endmodule : mis_top
`default_nettype wire

// File: tb/mis_host.sv
`timescale 1ns/1ps
`default_nettype none
module mis_host (
  // clock
  input  wire logic       mclk,
  // instruction strobes, one cycle each
  output logic            read_status_instr,
  output logic            start_pulse_instr,
  output logic            clear_pulse_instr,
  output logic            bus_reset_instr,
  output logic            pulse_instr,
  output logic            run_instr,
  output logic            run_with_clock_instr,
  output logic            pause_transfers_instr,
  output logic            base_addr_wr,
  output logic      [7:0] base_addr_wr_data
);
  logic [8:0] strb_q;
  logic [7:0] data_q;
  assign {base_addr_wr, pause_transfers_instr, run_with_clock_instr, run_instr, pulse_instr,
          bus_reset_instr, clear_pulse_instr, start_pulse_instr, read_status_instr} = strb_q;
  assign base_addr_wr_data = data_q;
  initial begin
    strb_q = 9'h000;
    data_q = 8'h00;
  end
  // strobes change on falling edges so the rising edge sees them settled
  task automatic instr(input logic [8:0] m, input logic [7:0] d);
    @(negedge mclk);
    strb_q = m;
    data_q = d;
    @(negedge mclk);
    strb_q = 9'h000;
  endtask : instr
  task automatic read_pop;
    instr(9'h080, 8'h00);
    instr(9'h003, 8'h00);
    instr(9'h020, 8'h00);
  endtask : read_pop
endmodule : mis_host
`default_nettype wire

// File: tb/mis_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mis_top_tb;
  import mis_pkg::*;
  localparam int tick_n = 40;
  logic        mclk, rst_b, read_status_instr, start_pulse_instr, clear_pulse_instr;
  logic        bus_reset_instr, pulse_instr, run_instr, run_with_clock_instr;
  logic        pause_transfers_instr, base_addr_wr, done_flag, intr_req, in_done_evt;
  logic        ob_load, ob_fetch_req, ob_fetch_strobe, mux_running, dc_enable, rtc_running;
  logic        data_out_idle, dev_ctrl_assert, port0_parity, port0_stop_two;
  logic [7:0]  base_addr_wr_data, pcb_base;
  logic [15:0] status_data, in_cw_addr, output_byte_pointer, last_output_byte_addr;
  logic [15:0] out_cw_addr, ob_fetch_addr;
  logic [1:0]  blk_size_sel, port0_char_len;
  logic [2:0]  port0_baud;
  int          bad_count, checked, cyc;
  mis_host i_host (.mclk, .read_status_instr, .start_pulse_instr, .clear_pulse_instr,
    .bus_reset_instr, .pulse_instr, .run_instr, .run_with_clock_instr,
    .pause_transfers_instr, .base_addr_wr, .base_addr_wr_data);
  mis_top #(.TICK_COUNT(tick_n)) i_dut (.mclk, .rst_b, .read_status_instr,
    .start_pulse_instr, .clear_pulse_instr, .bus_reset_instr, .pulse_instr, .run_instr,
    .run_with_clock_instr, .pause_transfers_instr, .base_addr_wr_data, .base_addr_wr,
    .status_data, .done_flag, .intr_req, .in_done_evt, .in_cw_addr, .blk_size_sel, .ob_load,
    .output_byte_pointer, .last_output_byte_addr, .out_cw_addr, .ob_fetch_req,
    .ob_fetch_addr, .ob_fetch_strobe, .mux_running, .dc_enable, .rtc_running,
    .data_out_idle, .dev_ctrl_assert, .port0_baud, .port0_char_len, .port0_parity,
    .port0_stop_two, .pcb_base);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic evt(input logic [15:0] a);
    @(negedge mclk);
    in_done_evt = 1'b1;
    in_cw_addr = a;
    @(negedge mclk);
    in_done_evt = 1'b0;
  endtask : evt
  task automatic t_ctrl;
    chk("rst", {status_data[3:0], done_flag, data_out_idle}, 16'h1);
    i_host.instr(9'h100, 8'h5a);
    i_host.instr(9'h040, 8'h00);
    chk("runc", {mux_running, rtc_running, data_out_idle}, 16'h6);
    i_host.instr(9'h100, 8'h33);
    i_host.instr(9'h004, 8'h00);
    chk("clr", {mux_running, rtc_running, data_out_idle, done_flag}, 16'h2);
    chk("keep", pcb_base, 16'h5a);
    i_host.instr(9'h010, 8'h00);
    chk("pls", {mux_running, rtc_running}, 16'h1);
    i_host.instr(9'h008, 8'h00);
    chk("brst", {rtc_running, dev_ctrl_assert, pcb_base}, {8'h1, BASE_DEFAULT});
    chk("p0", {port0_baud, port0_char_len, port0_parity, port0_stop_two},
        {BAUD_9600, CHAR_LEN_8, PARITY_NONE, STOP_TWO});
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_ids;
    for (int s = 0; s < 3; s++) begin
      blk_size_sel = 2'(s);
      evt((16'h55 << (5 - s)) | 16'h8007);
      i_host.read_pop();
      chk("id", status_data, 16'h0554);
    end
    blk_size_sel = BLK_40_OCT;
    for (int i = 1; i < 4; i++) evt(16'(i) << 5);
    chk("irq", intr_req, 16'h1);
    chk("done", done_flag, 16'h1);
    for (int i = 1; i < 4; i++) begin
      i_host.read_pop();
      chk("fifo", status_data, 16'(i) << 4 | 16'h4);
      chk("more", done_flag, 16'(i < 3));
    end
    i_host.instr(9'h001, 8'h00);
    chk("empty", status_data[3:0], 16'h0);
    i_host.instr(9'h002, 8'h00);
    chk("st", done_flag, 16'h0);
    $display("test ids done");
  endtask : t_ids
  task automatic t_ovf;
    repeat (41) evt(16'h20);
    i_host.instr(9'h001, 8'h00);
    chk("ovf", {done_flag, status_data[3:0]}, 16'h12);
    i_host.instr(9'h002, 8'h00);
    chk("flush", done_flag, 16'h0);
    evt(16'h40);
    i_host.read_pop();
    chk("requeue", status_data, 16'h0024);
    $display("test ovf done");
  endtask : t_ovf
  task automatic t_ob(input logic [15:0] p, input logic [15:0] l);
    i_host.instr(9'h080, 8'h00);
    @(negedge mclk);
    ob_load = 1'b1;
    output_byte_pointer = p;
    last_output_byte_addr = l;
    @(negedge mclk);
    ob_load = 1'b0;
    ob_fetch_req = 1'b1;
    repeat (3) @(negedge mclk);
    chk("pause", {dc_enable, ob_fetch_strobe}, 16'h0);
    i_host.instr(9'h020, 8'h00);
    for (int n = 0; n < 20 && ob_fetch_strobe !== 1'b1; n++) @(negedge mclk);
    chk("fetch", ob_fetch_addr, p + 16'h1);
    ob_fetch_req = 1'b0;
    repeat (4) @(negedge mclk);
    i_host.read_pop();
    chk("odone", status_data, 16'h0538);
    chk("one", done_flag, 16'h0);
    $display("test ob done");
  endtask : t_ob
  task automatic t_tick;
    i_host.instr(9'h010, 8'h00);
    evt(16'h20);
    repeat (tick_n + 2) @(negedge mclk);
    i_host.read_pop();
    chk("tick", status_data, 16'h0015);
    i_host.instr(9'h001, 8'h00);
    chk("tclr", status_data[3:0], 16'h0);
    i_host.instr(9'h004, 8'h00);
    $display("test tick done");
  endtask : t_tick
  // a hang counts as a mismatch and still reaches the report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    {in_done_evt, ob_load, ob_fetch_req, blk_size_sel} = '0;
    {in_cw_addr, output_byte_pointer, last_output_byte_addr} = '0;
    out_cw_addr = 16'h0a60;
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    t_ctrl();
    t_ids();
    t_ovf();
    t_ob(16'h0100, 16'h0101);
    t_ob(16'h0200, 16'h0010);
    t_tick();
    finish_test();
  end
endmodule : mis_top_tb
`default_nettype wire
